// file: rtl/ttcm_top.sv
// three timer/counter units behind an 8-bit register port.
// assumes pins are synchronous to clk_in and clk_in is the oscillator clock.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps

module ttcm_top #(
    parameter int OSC_DIV = ttcm_pkg::OSC_PER_MC
) (
    input wire logic clk_in, // oscillator clock
    input wire logic rst_in, // async reset, active high
    input wire logic [ttcm_pkg::ADDR_W-1:0] addr_in, // register address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [7:0] rdata_out, // read data, cycle after rd_in
    input wire logic unit_a_count_pin_in, // unit a external count pin
    input wire logic unit_b_count_pin_in, // unit b external count pin
    input wire logic unit_a_gate_pin_in, // unit a gate pin
    input wire logic unit_b_gate_pin_in, // unit b gate pin
    input wire logic unit_c_count_pin_in, // unit c external count pin
    input wire logic unit_c_trigger_pin_in, // unit c trigger pin
    output logic unit_a_overflow_flag_out, // unit a overflow flag
    output logic unit_b_overflow_flag_out, // unit b overflow flag
    output logic unit_c_irq_out // unit c interrupt request
);

    ttcm_pkg::ttcm_state_t s_q;
    ttcm_pkg::ttcm_state_t s_d;

    logic tick;
    logic [1:0] cnt_pin;
    logic [1:0] gate_pin;
    logic [1:0] fall;
    logic [1:0] ev;
    logic [1:0] ovf_set;
    logic [3:0] cfg;
    logic [12:0] cnt13;
    logic [15:0] cnt16;
    logic a_split;
    logic en;
    logic c_ev;
    logic trig_ev;
    logic baud;
    logic capture;
    logic c_ovf_set;
    logic c_ext_set;
    logic [7:0] rd_val;

    localparam logic [ttcm_pkg::MC_W-1:0] MC_END = ttcm_pkg::MC_W'(OSC_DIV - 1);

    assign cnt_pin = {unit_b_count_pin_in, unit_a_count_pin_in};
    assign gate_pin = {unit_b_gate_pin_in, unit_a_gate_pin_in};

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        ovf_set = 2'h0;
        cfg = 4'h0;
        cnt13 = 13'h0000;
        cnt16 = 16'h0000;
        en = 1'b0;
        c_ovf_set = 1'b0;
        c_ext_set = 1'b0;
        rd_val = 8'h00;

        // machine cycle divider
        tick = (s_q.mc_cnt == MC_END);
        s_d.mc_cnt = tick ? '0 : s_q.mc_cnt + 4'h1;

        // pin samples taken once per machine cycle; edge is high sample then low sample
        fall = {2{tick}} & s_q.pin_smp & ~cnt_pin;
        c_ev = tick & s_q.c_pin_smp & ~unit_c_count_pin_in;
        trig_ev = tick & s_q.trig_smp & ~unit_c_trigger_pin_in;
        if (tick) begin
            s_d.pin_smp = cnt_pin;
            s_d.c_pin_smp = unit_c_count_pin_in;
            s_d.trig_smp = unit_c_trigger_pin_in;
        end

        a_split = (s_q.mode_cfg[0][1:0] == ttcm_pkg::MODE_SPLIT);

        // units a and b
        for (int u = 0; u < 2; u++) begin
            cfg = s_q.mode_cfg[u];
            ev[u] = cfg[ttcm_pkg::CFG_SRC] ? fall[u] : tick;
            // unit b loses its run bit to unit a's high byte while a is split
            en = ev[u] & (~cfg[ttcm_pkg::CFG_GATE] | gate_pin[u])
                & (((u == 1) && a_split) ? 1'b1 : s_q.run[u]);
            if (en) begin
                case (cfg[1:0])
                    ttcm_pkg::MODE_13BIT: begin
                        cnt13 = {s_q.hi[u], s_q.lo[u][4:0]} + 13'h0001;
                        s_d.hi[u] = cnt13[12:5];
                        s_d.lo[u][4:0] = cnt13[4:0];
                        if ({s_q.hi[u], s_q.lo[u][4:0]} == ttcm_pkg::CNT13_MAX) begin
                            ovf_set[u] = 1'b1;
                        end
                    end
                    ttcm_pkg::MODE_16BIT: begin
                        cnt16 = {s_q.hi[u], s_q.lo[u]} + 16'h0001;
                        s_d.hi[u] = cnt16[15:8];
                        s_d.lo[u] = cnt16[7:0];
                        if ({s_q.hi[u], s_q.lo[u]} == ttcm_pkg::CNT16_MAX) begin
                            ovf_set[u] = 1'b1;
                        end
                    end
                    ttcm_pkg::MODE_RELOAD8: begin
                        if (s_q.lo[u] == ttcm_pkg::BYTE_MAX) begin
                            s_d.lo[u] = s_q.hi[u];
                            ovf_set[u] = 1'b1;
                        end else begin
                            s_d.lo[u] = s_q.lo[u] + 8'h01;
                        end
                    end
                    default: begin
                        if (u == 0) begin
                            s_d.lo[u] = s_q.lo[u] + 8'h01;
                            if (s_q.lo[u] == ttcm_pkg::BYTE_MAX) begin
                                ovf_set[u] = 1'b1;
                            end
                        end
                        // unit b split: no update at all, count held
                    end
                endcase
            end
        end

        // unit b cannot raise its own flag while unit a's high byte owns it
        if (a_split) begin
            ovf_set[1] = 1'b0;
            if (tick && s_q.run[1]) begin
                s_d.hi[0] = s_q.hi[0] + 8'h01;
                if (s_q.hi[0] == ttcm_pkg::BYTE_MAX) begin
                    ovf_set[1] = 1'b1;
                end
            end
        end

        // unit c
        baud = s_q.c_ctrl[ttcm_pkg::C_RX_SEL] | s_q.c_ctrl[ttcm_pkg::C_TX_SEL]
            | s_q.ser2_sel[ttcm_pkg::S2_RX_SEL] | s_q.ser2_sel[ttcm_pkg::S2_TX_SEL];
        capture = s_q.c_ctrl[ttcm_pkg::C_CAPTURE] & ~baud;
        if (s_q.c_ctrl[ttcm_pkg::C_RUN]
            && (s_q.c_ctrl[ttcm_pkg::C_SRC] ? c_ev : tick)) begin
            if (s_q.c_cnt == ttcm_pkg::CNT16_MAX) begin
                s_d.c_cnt = capture ? 16'h0000 : s_q.c_cap;
                c_ovf_set = ~baud;
            end else begin
                s_d.c_cnt = s_q.c_cnt + 16'h0001;
            end
        end
        if (trig_ev && s_q.c_ctrl[ttcm_pkg::C_EXT_EN]) begin
            c_ext_set = 1'b1;
            if (baud) begin
                // extra external interrupt only
            end else if (capture) begin
                s_d.c_cap = s_q.c_cnt;
            end else begin
                s_d.c_cnt = s_q.c_cap;
            end
        end

        // register writes; flags keep a same-cycle hardware set
        if (wr_in) begin
            if (addr_in == ttcm_pkg::OFF_MODE_CFG) begin
                s_d.mode_cfg = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_RUN_FLAG) begin
                s_d.run = {wdata_in[ttcm_pkg::RF_B_RUN], wdata_in[ttcm_pkg::RF_A_RUN]};
                s_d.ovf = {wdata_in[ttcm_pkg::RF_B_FLAG], wdata_in[ttcm_pkg::RF_A_FLAG]};
            end else if (addr_in == ttcm_pkg::OFF_A_LOW) begin
                s_d.lo[0] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_A_HIGH) begin
                s_d.hi[0] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_B_LOW) begin
                s_d.lo[1] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_B_HIGH) begin
                s_d.hi[1] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_C_CTRL) begin
                s_d.c_ctrl = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_C_LOW) begin
                s_d.c_cnt[7:0] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_C_HIGH) begin
                s_d.c_cnt[15:8] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_C_CAP_LOW) begin
                s_d.c_cap[7:0] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_C_CAP_HIGH) begin
                s_d.c_cap[15:8] = wdata_in;
            end else if (addr_in == ttcm_pkg::OFF_SER2_SEL) begin
                s_d.ser2_sel = {wdata_in[ttcm_pkg::S2_RX_SEL], wdata_in[ttcm_pkg::S2_TX_SEL]};
            end
        end
        s_d.ovf = s_d.ovf | ovf_set;
        s_d.c_ctrl[ttcm_pkg::C_OVF] = s_d.c_ctrl[ttcm_pkg::C_OVF] | c_ovf_set;
        s_d.c_ctrl[ttcm_pkg::C_EXT] = s_d.c_ctrl[ttcm_pkg::C_EXT] | c_ext_set;
        s_d.c_irq = s_d.c_ctrl[ttcm_pkg::C_OVF] | s_d.c_ctrl[ttcm_pkg::C_EXT];

        // read path: stored values, unmapped addresses read zero
        if (addr_in == ttcm_pkg::OFF_MODE_CFG) begin
            rd_val = s_q.mode_cfg;
        end else if (addr_in == ttcm_pkg::OFF_RUN_FLAG) begin
            rd_val[ttcm_pkg::RF_A_RUN] = s_q.run[0];
            rd_val[ttcm_pkg::RF_A_FLAG] = s_q.ovf[0];
            rd_val[ttcm_pkg::RF_B_RUN] = s_q.run[1];
            rd_val[ttcm_pkg::RF_B_FLAG] = s_q.ovf[1];
        end else if (addr_in == ttcm_pkg::OFF_A_LOW) begin
            rd_val = s_q.lo[0];
        end else if (addr_in == ttcm_pkg::OFF_A_HIGH) begin
            rd_val = s_q.hi[0];
        end else if (addr_in == ttcm_pkg::OFF_B_LOW) begin
            rd_val = s_q.lo[1];
        end else if (addr_in == ttcm_pkg::OFF_B_HIGH) begin
            rd_val = s_q.hi[1];
        end else if (addr_in == ttcm_pkg::OFF_C_CTRL) begin
            rd_val = s_q.c_ctrl;
        end else if (addr_in == ttcm_pkg::OFF_C_LOW) begin
            rd_val = s_q.c_cnt[7:0];
        end else if (addr_in == ttcm_pkg::OFF_C_HIGH) begin
            rd_val = s_q.c_cnt[15:8];
        end else if (addr_in == ttcm_pkg::OFF_C_CAP_LOW) begin
            rd_val = s_q.c_cap[7:0];
        end else if (addr_in == ttcm_pkg::OFF_C_CAP_HIGH) begin
            rd_val = s_q.c_cap[15:8];
        end else if (addr_in == ttcm_pkg::OFF_SER2_SEL) begin
            rd_val[ttcm_pkg::S2_RX_SEL] = s_q.ser2_sel[1];
            rd_val[ttcm_pkg::S2_TX_SEL] = s_q.ser2_sel[0];
        end
        s_d.rdata = rd_in ? rd_val : 8'h00;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign unit_a_overflow_flag_out = s_q.ovf[0];
    assign unit_b_overflow_flag_out = s_q.ovf[1];
    assign unit_c_irq_out = s_q.c_irq;

endmodule // ttcm_top

// file: pkg/ttcm_pkg.sv
// constants and types of the triple timer/counter block.
// assumes an 8-bit register port and one clock that stands in for the oscillator.
package ttcm_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_MODE_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RUN_FLAG = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_A_LOW = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_A_HIGH = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_B_LOW = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_B_HIGH = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_C_CTRL = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_C_LOW = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_C_HIGH = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_C_CAP_LOW = 4'h9;
    localparam logic [ADDR_W-1:0] OFF_C_CAP_HIGH = 4'hA;
    localparam logic [ADDR_W-1:0] OFF_SER2_SEL = 4'hB;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    // per-unit nibble of timer_mode_config
    localparam int CFG_GATE = 3;
    localparam int CFG_SRC = 2;
    // run/flag register: unit a in bits 5:4, unit b in bits 7:6
    localparam int RF_A_RUN = 4;
    localparam int RF_A_FLAG = 5;
    localparam int RF_B_RUN = 6;
    localparam int RF_B_FLAG = 7;
    // third_timer_control
    localparam int C_OVF = 7;
    localparam int C_EXT = 6;
    localparam int C_RX_SEL = 5;
    localparam int C_TX_SEL = 4;
    localparam int C_EXT_EN = 3;
    localparam int C_RUN = 2;
    localparam int C_SRC = 1;
    localparam int C_CAPTURE = 0;
    // second serial clock selects
    localparam int S2_RX_SEL = 1;
    localparam int S2_TX_SEL = 0;

    // ---------------------------------------------------------------
    // modes and timing
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam int OSC_PER_MC = 12;
    localparam int MC_W = 4;
    localparam logic [MC_W-1:0] MC_LAST = MC_W'(OSC_PER_MC - 1);
    localparam logic [4:0] PRESC_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [12:0] CNT13_MAX = 13'h1FFF;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;

    // ---------------------------------------------------------------
    // whole state of the block
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0][3:0] mode_cfg;
        logic [1:0] run;
        logic [1:0] ovf;
        logic [1:0][7:0] lo;
        logic [1:0][7:0] hi;
        logic [7:0] c_ctrl;
        logic [1:0] ser2_sel;
        logic [15:0] c_cnt;
        logic [15:0] c_cap;
        logic [MC_W-1:0] mc_cnt;
        logic [1:0] pin_smp;
        logic c_pin_smp;
        logic trig_smp;
        logic c_irq;
        logic [7:0] rdata;
    } ttcm_state_t;

endpackage

// file: verif/ttcm_properties.sv
// port checker of the triple timer block.
// assumes it is bound onto ttcm_top; it keeps its own machine-cycle count from reset release.
`timescale 1ns/10ps
module ttcm_checker #(
    parameter int OSC_DIV = 12
) (
    input wire logic clk_in, // clock
    input wire logic rst_in, // async reset
    input wire logic [ttcm_pkg::ADDR_W-1:0] addr_in, // address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [7:0] rdata_out, // read data
    input wire logic unit_a_overflow_flag_out, // unit a flag
    input wire logic unit_b_overflow_flag_out, // unit b flag
    input wire logic unit_c_irq_out // unit c request
);
    logic [7:0] mc_q;
    logic tick;
    assign tick = (mc_q == 8'(OSC_DIV - 1));
    // mirrors the divider so flag moves can be pinned to machine ticks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) mc_q <= 8'h00;
        else mc_q <= tick ? 8'h00 : mc_q + 8'h01;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    rd_idle_a: assert property (
        !$past(rd_in) |-> rdata_out == 8'h00) else $error("read data not zero outside read");
    rd_unmapped_a: assert property (
        rd_in && addr_in > ttcm_pkg::OFF_SER2_SEL |=> rdata_out == 8'h00) else $error("unmapped read not zero");
    flag_view_a: assert property (
        rd_in && addr_in == ttcm_pkg::OFF_RUN_FLAG |=> rdata_out[7] == $past(unit_b_overflow_flag_out)
        && rdata_out[5] == $past(unit_a_overflow_flag_out)) else $error("flag bits differ from flag pins");
    a_sticky_a: assert property (
        unit_a_overflow_flag_out && !(wr_in && addr_in == ttcm_pkg::OFF_RUN_FLAG) |=> unit_a_overflow_flag_out)
        else $error("unit a flag dropped");
    b_sticky_a: assert property (
        unit_b_overflow_flag_out && !(wr_in && addr_in == ttcm_pkg::OFF_RUN_FLAG) |=> unit_b_overflow_flag_out)
        else $error("unit b flag dropped");
    a_rise_tick_a: assert property (
        $rose(unit_a_overflow_flag_out) && !$past(wr_in) |-> $past(tick)) else $error("unit a flag off tick");
    irq_rise_tick_a: assert property (
        $rose(unit_c_irq_out) && !$past(wr_in) |-> $past(tick)) else $error("unit c request off tick");
    a_clear_a: assert property (
        wr_in && addr_in == ttcm_pkg::OFF_RUN_FLAG && !wdata_in[ttcm_pkg::RF_A_FLAG] && !tick
        |=> !unit_a_overflow_flag_out) else $error("unit a flag not cleared");
    irq_clear_a: assert property (
        wr_in && addr_in == ttcm_pkg::OFF_C_CTRL && wdata_in[7:6] == 2'h0 && !tick
        |=> !unit_c_irq_out) else $error("unit c request not cleared");
endmodule // ttcm_checker

bind ttcm_top ttcm_checker #(.OSC_DIV(OSC_DIV)) ttcm_checker_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .unit_a_overflow_flag_out(unit_a_overflow_flag_out), .unit_b_overflow_flag_out(unit_b_overflow_flag_out),
    .unit_c_irq_out(unit_c_irq_out));

// file: verif/ttcm_pins.sv
// model of the external pins: count, gate and trigger sources.
// assumes HOLD covers at least one machine cycle of the block.
`timescale 1ns/10ps
module ttcm_pins #(
    parameter int HOLD = 24
) (
    input wire logic clk_in, // clock
    output logic [3:0] pin_out, // a, b, c count pins, trigger pin
    output logic [1:0] gate_out // a, b gate pins
);
    initial pin_out = 4'h0;
    initial gate_out = 2'h0;
    // each level is held a full HOLD so no edge is lost between samples
    task automatic fall(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            pin_out[sel] <= 1'b1;
            repeat (HOLD) @(posedge clk_in);
            pin_out[sel] <= 1'b0;
            repeat (HOLD) @(posedge clk_in);
        end
    endtask
    task automatic gate(input int sel, input logic v);
        @(posedge clk_in);
        gate_out[sel] <= v;
    endtask
endmodule // ttcm_pins

// file: verif/tb.sv
// self-checking bench of the triple timer block.
// assumes the checker is bound by its own file; pins come from ttcm_pins.
`timescale 1ns/10ps
module tb;
    localparam int DIV = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ttcm_pkg::ADDR_W-1:0] addr_in = '0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [3:0] pin;
    logic [1:0] gate;
    logic fa, fb, irq;
    int mismatches = 0;
    int total_checks = 0;
    always #2 clk_in = ~clk_in;
    ttcm_top #(.OSC_DIV(DIV)) ttcm_top_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .unit_a_count_pin_in(pin[0]), .unit_b_count_pin_in(pin[1]), .unit_a_gate_pin_in(gate[0]),
        .unit_b_gate_pin_in(gate[1]), .unit_c_count_pin_in(pin[2]), .unit_c_trigger_pin_in(pin[3]),
        .unit_a_overflow_flag_out(fa), .unit_b_overflow_flag_out(fb), .unit_c_irq_out(irq));
    ttcm_pins #(.HOLD(2 * DIV)) ttcm_pins_i (.clk_in(clk_in), .pin_out(pin), .gate_out(gate));
    // ---------------------------------------------------------------
    // access and compare tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp);
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 13; a++) rc(4'(a), 8'h00);
        $display("test reset done");
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h05);
        wr(ttcm_pkg::OFF_A_LOW, 8'hFE);
        wr(ttcm_pkg::OFF_A_HIGH, 8'hFF);
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h10);
        rc(ttcm_pkg::OFF_A_LOW, 8'hFE);
        ttcm_pins_i.fall(0, 3);
        rc(ttcm_pkg::OFF_A_LOW, 8'h01);
        rc(ttcm_pkg::OFF_A_HIGH, 8'h00);
        check({7'h00, fa}, 8'h01);
        rc(ttcm_pkg::OFF_RUN_FLAG, 8'h30);
        $display("test cascade done");
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h10);
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h0D);
        wr(ttcm_pkg::OFF_A_LOW, 8'h00);
        ttcm_pins_i.fall(0, 2);
        rc(ttcm_pkg::OFF_A_LOW, 8'h00);
        ttcm_pins_i.gate(0, 1'b1);
        ttcm_pins_i.fall(0, 2);
        rc(ttcm_pkg::OFF_A_LOW, 8'h02);
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h00);
        ttcm_pins_i.fall(0, 1);
        rc(ttcm_pkg::OFF_A_LOW, 8'h02);
        $display("test gate done");
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h40);
        wr(ttcm_pkg::OFF_B_LOW, 8'hFE);
        wr(ttcm_pkg::OFF_B_HIGH, 8'h00);
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h40);
        ttcm_pins_i.fall(1, 3);
        rc(ttcm_pkg::OFF_B_LOW, 8'hE1);
        rc(ttcm_pkg::OFF_B_HIGH, 8'h01);
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h60);
        wr(ttcm_pkg::OFF_B_LOW, 8'hFE);
        wr(ttcm_pkg::OFF_B_HIGH, 8'h80);
        ttcm_pins_i.fall(1, 3);
        rc(ttcm_pkg::OFF_B_LOW, 8'h81);
        rc(ttcm_pkg::OFF_B_HIGH, 8'h80);
        rc(ttcm_pkg::OFF_RUN_FLAG, 8'hC0);
        check({7'h00, fb}, 8'h01);
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h70);
        ttcm_pins_i.fall(1, 2);
        rc(ttcm_pkg::OFF_B_LOW, 8'h81);
        $display("test unit b modes done");
        // unit a split: its high byte runs as a timer on unit b's run bit and flag
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h00);
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h03);
        wr(ttcm_pkg::OFF_A_HIGH, 8'hFF);
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h40);
        repeat (3 * DIV) @(posedge clk_in);
        check({7'h00, fb}, 8'h01);
        check({7'h00, fa}, 8'h00);
        rc(ttcm_pkg::OFF_RUN_FLAG, 8'hC0);
        wr(ttcm_pkg::OFF_RUN_FLAG, 8'h00);
        wr(ttcm_pkg::OFF_MODE_CFG, 8'h00);
        $display("test split done");
        wr(ttcm_pkg::OFF_C_LOW, 8'h10);
        wr(ttcm_pkg::OFF_C_HIGH, 8'h20);
        wr(ttcm_pkg::OFF_C_CTRL, 8'h0F);
        ttcm_pins_i.fall(2, 2);
        rc(ttcm_pkg::OFF_C_LOW, 8'h12);
        ttcm_pins_i.fall(3, 1);
        rc(ttcm_pkg::OFF_C_CAP_LOW, 8'h12);
        rc(ttcm_pkg::OFF_C_CAP_HIGH, 8'h20);
        check({7'h00, irq}, 8'h01);
        rc(ttcm_pkg::OFF_C_CTRL, 8'h4F);
        $display("test capture done");
        wr(ttcm_pkg::OFF_C_CTRL, 8'h0E);
        wr(ttcm_pkg::OFF_C_CAP_LOW, 8'h34);
        wr(ttcm_pkg::OFF_C_CAP_HIGH, 8'h12);
        wr(ttcm_pkg::OFF_C_LOW, 8'hFE);
        wr(ttcm_pkg::OFF_C_HIGH, 8'hFF);
        ttcm_pins_i.fall(2, 2);
        rc(ttcm_pkg::OFF_C_LOW, 8'h34);
        rc(ttcm_pkg::OFF_C_HIGH, 8'h12);
        rc(ttcm_pkg::OFF_C_CTRL, 8'h8E);
        ttcm_pins_i.fall(2, 1);
        ttcm_pins_i.fall(3, 1);
        rc(ttcm_pkg::OFF_C_LOW, 8'h34);
        rc(ttcm_pkg::OFF_C_CTRL, 8'hCE);
        $display("test reload done");
        wr(ttcm_pkg::OFF_SER2_SEL, 8'h01);
        wr(ttcm_pkg::OFF_C_CTRL, 8'h07);
        wr(ttcm_pkg::OFF_C_LOW, 8'hFF);
        wr(ttcm_pkg::OFF_C_HIGH, 8'hFF);
        ttcm_pins_i.fall(2, 1);
        rc(ttcm_pkg::OFF_C_LOW, 8'h34);
        rc(ttcm_pkg::OFF_C_CTRL, 8'h07);
        wr(ttcm_pkg::OFF_SER2_SEL, 8'h00);
        wr(ttcm_pkg::OFF_C_CTRL, 8'h02);
        ttcm_pins_i.fall(2, 1);
        rc(ttcm_pkg::OFF_C_LOW, 8'h34);
        $display("test baud and stop done");
        end_sim();
    end
endmodule // tb
